// ### hdl/interrupt_and_halt_control.sv
// The placing of the registers and register access over APB were decided locally.
module interrupt_and_halt_control #(
	parameter int STACK_DEPTH = irq_halt_pkg::STACK_DEPTH
) (
	// Clock and reset.
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	// Register bus.
	input  wire irq_halt_pkg::apb_req_t        apbReq,
	output      irq_halt_pkg::apb_rsp_t        apbRsp,
	// Event sources and pins.
	input  wire logic                          timer8Event,
	input  wire logic                          intervalTimerEvent,
	input  wire logic                          extIntPin,
	input  wire logic [irq_halt_pkg::PORT_W-1:0] wakePortAPins,
	input  wire logic [irq_halt_pkg::PORT_W-1:0] wakePortBPins,
	// Instruction sequencer.
	input  wire irq_halt_pkg::seq_cmd_t        seqCmd,
	output      irq_halt_pkg::seq_rsp_t        seqRsp
);

	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	localparam int SRC_N = irq_halt_pkg::SRC_N;

	irq_halt_pkg::standby_state_t  state_reg;
	irq_halt_pkg::stack_entry_t    stack_reg [STACK_DEPTH];
	logic [irq_halt_pkg::CTRL_W-1:0] ctrl_reg;
	logic [SRC_N-1:0]              req_reg;
	logic [SRC_N-1:0]              req_next;
	logic [SRC_N-1:0]              enableVec;
	logic [SRC_N-1:0]              enabledPend;
	logic [SRC_N-1:0]              setEvents;
	logic [SRC_N-1:0]              clearMask;
	logic [SRC_N-1:0]              baseReq;
	logic [SRC_N-1:0]              takeSel;
	logic [irq_halt_pkg::PC_W-1:0] takeVector;
	logic [SP_W-1:0]               sp_reg;
	logic [SP_W-1:0]               spBase;
	logic                          extPinPrev_reg;
	logic                          pinPrimed_reg;
	logic                          masterEnable_reg;
	logic                          masterArm_reg;
	logic                          take_reg;
	logic [irq_halt_pkg::PC_W-1:0] vector_reg;
	logic                          resume_reg;
	logic                          restoreValid_reg;
	irq_halt_pkg::stack_entry_t    restore_reg;
	logic [irq_halt_pkg::DATA_W-1:0] prdata_reg;
	logic                          slverr_reg;
	logic                          extEdge;
	logic                          apbWrite;
	logic                          apbSetup;
	logic                          writeCtrl;
	logic                          writeReq;
	logic                          inRun;
	logic                          halted;
	logic                          portsAllHigh;
	logic                          portLow;
	logic                          acceptGate;
	logic                          normalTake;
	logic                          haltRelease;
	logic                          haltBranch;
	logic                          haltTake;
	logic                          haltResume;
	logic                          take;
	logic                          popDo;
	logic                          pushDo;
	logic                          stopRelease;

	assign apbWrite  = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign apbSetup  = apbReq.psel & ~apbReq.penable;
	assign writeCtrl = apbWrite & (apbReq.paddr == irq_halt_pkg::CTRL_OFFSET);
	assign writeReq  = apbWrite & (apbReq.paddr == irq_halt_pkg::REQ_OFFSET);

	assign inRun        = (state_reg == irq_halt_pkg::ST_RUN);
	assign halted       = (state_reg == irq_halt_pkg::ST_HALT_TIMER) ||
	                      (state_reg == irq_halt_pkg::ST_HALT_ANY);
	assign portsAllHigh = &{wakePortAPins, wakePortBPins};
	assign portLow      = ~portsAllHigh;
	assign stopRelease  = (state_reg == irq_halt_pkg::ST_STOP) & portLow;

	// The first sample after reset only primes the edge detector, so a pin that is
	// already high when reset lifts does not look like a rising edge.
	assign extEdge = pinPrimed_reg & (ctrl_reg[irq_halt_pkg::CTRL_EDGE_BIT] ?
	                 (extPinPrev_reg & ~extIntPin) : (~extPinPrev_reg & extIntPin));

	always_comb begin
		enableVec = '0;
		enableVec[irq_halt_pkg::SRC_TIMER8]   = ctrl_reg[irq_halt_pkg::CTRL_T8_EN_BIT];
		enableVec[irq_halt_pkg::SRC_EXT]      = ctrl_reg[irq_halt_pkg::CTRL_EXT_EN_BIT];
		enableVec[irq_halt_pkg::SRC_INTERVAL] = ctrl_reg[irq_halt_pkg::CTRL_INT_EN_BIT];
		setEvents = '0;
		setEvents[irq_halt_pkg::SRC_TIMER8]   = timer8Event;
		setEvents[irq_halt_pkg::SRC_EXT]      = extEdge;
		setEvents[irq_halt_pkg::SRC_INTERVAL] = intervalTimerEvent;
	end

	assign enabledPend = req_reg & enableVec;

	// Fixed priority pick among enabled pending sources.
	always_comb begin
		takeSel    = '0;
		takeVector = irq_halt_pkg::VEC_INTERVAL;
		if (enabledPend[irq_halt_pkg::SRC_TIMER8]) begin
			takeSel[irq_halt_pkg::SRC_TIMER8] = 1'b1;
			takeVector = irq_halt_pkg::VEC_TIMER8;
		end else if (enabledPend[irq_halt_pkg::SRC_EXT]) begin
			takeSel[irq_halt_pkg::SRC_EXT] = 1'b1;
			takeVector = irq_halt_pkg::VEC_EXT;
		end else if (enabledPend[irq_halt_pkg::SRC_INTERVAL]) begin
			takeSel[irq_halt_pkg::SRC_INTERVAL] = 1'b1;
			takeVector = irq_halt_pkg::VEC_INTERVAL;
		end
	end

	// An armed enable counts at the boundary that closes the following instruction.
	assign acceptGate = (masterEnable_reg | masterArm_reg) & ~seqCmd.masterDisableInstr;
	assign normalTake = inRun & seqCmd.cycleEnd & ~seqCmd.secondPending &
	                    acceptGate & (|enabledPend);

	always_comb begin
		haltRelease = 1'b0;
		haltBranch  = 1'b0;
		unique case (state_reg)
			irq_halt_pkg::ST_RUN: begin
				haltRelease = 1'b0;
			end
			irq_halt_pkg::ST_HALT_TIMER: begin
				haltRelease = req_reg[irq_halt_pkg::SRC_TIMER8];
				haltBranch  = masterEnable_reg & enableVec[irq_halt_pkg::SRC_TIMER8];
			end
			irq_halt_pkg::ST_HALT_ANY: begin
				haltRelease = portLow | (|enabledPend);
				haltBranch  = masterEnable_reg & (|enabledPend);
			end
			irq_halt_pkg::ST_STOP: begin
				haltRelease = 1'b0;
			end
		endcase
	end

	assign haltTake   = halted & haltRelease & haltBranch;
	assign haltResume = halted & haltRelease & ~haltBranch;
	assign take       = normalTake | haltTake;

	// Standby state machine.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= irq_halt_pkg::ST_RUN;
		end else begin
			unique case (state_reg)
				irq_halt_pkg::ST_RUN: begin
					// Entry is judged on the flags as they stand, so clearing an enabled
					// request just before the halt can leave a stale view behind.
					if (seqCmd.cycleEnd & ~seqCmd.secondPending & ~normalTake) begin
						if (seqCmd.haltInstr & (seqCmd.operand == irq_halt_pkg::HALT_OP_TIMER) &
						    ~req_reg[irq_halt_pkg::SRC_TIMER8]) begin
							state_reg <= irq_halt_pkg::ST_HALT_TIMER;
						end else if (seqCmd.haltInstr &
						             (seqCmd.operand == irq_halt_pkg::HALT_OP_ANY) &
						             (enabledPend == '0) & portsAllHigh) begin
							state_reg <= irq_halt_pkg::ST_HALT_ANY;
						end else if (seqCmd.stopInstr &
						             (seqCmd.operand == irq_halt_pkg::STOP_OP_PORT) &
						             portsAllHigh) begin
							state_reg <= irq_halt_pkg::ST_STOP;
						end
						// Any other halt or stop falls through as a no-operation.
					end
				end
				irq_halt_pkg::ST_HALT_TIMER, irq_halt_pkg::ST_HALT_ANY: begin
					if (haltRelease) begin
						state_reg <= irq_halt_pkg::ST_RUN;
					end
				end
				irq_halt_pkg::ST_STOP: begin
					// After stop the core waits in timer halt for the oscillator to settle.
					if (portLow) begin
						state_reg <= irq_halt_pkg::ST_HALT_TIMER;
					end
				end
			endcase
		end
	end

	// Request flags: a source event wins over an acceptance clear or a software 0.
	always_comb begin
		baseReq   = writeReq ? apbReq.pwdata[SRC_N-1:0] : req_reg;
		clearMask = take ? takeSel : '0;
		if (stopRelease) begin
			clearMask[irq_halt_pkg::SRC_TIMER8] = 1'b1;
		end
		req_next = (baseReq & ~clearMask) | setEvents;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			req_reg <= irq_halt_pkg::REQ_RESET;
		end else begin
			req_reg <= req_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_reg <= irq_halt_pkg::CTRL_RESET;
		end else if (writeCtrl) begin
			ctrl_reg <= apbReq.pwdata[irq_halt_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			extPinPrev_reg <= 1'b0;
			pinPrimed_reg  <= 1'b0;
		end else begin
			extPinPrev_reg <= extIntPin;
			pinPrimed_reg  <= 1'b1;
		end
	end

	// Master enable is not visible on the register bus.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			masterEnable_reg <= 1'b0;
			masterArm_reg    <= 1'b0;
		end else begin
			if (take) begin
				masterEnable_reg <= 1'b0;
			end else if (seqCmd.cycleEnd & seqCmd.masterDisableInstr) begin
				masterEnable_reg <= 1'b0;
			end else if (seqCmd.cycleEnd & masterArm_reg) begin
				masterEnable_reg <= 1'b1;
			end
			if (seqCmd.cycleEnd) begin
				masterArm_reg <= seqCmd.masterEnableInstr & ~seqCmd.masterDisableInstr;
			end
		end
	end

	// Hardware stack; a push beyond the last level is dropped.
	assign popDo  = inRun & seqCmd.cycleEnd & seqCmd.returnInstr & (sp_reg != '0);
	assign spBase = popDo ? SP_W'(sp_reg - 1'b1) : sp_reg;
	assign pushDo = take & (spBase < SP_W'(STACK_DEPTH));

	always_ff @(posedge clk_sys) begin
		if (pushDo) begin
			stack_reg[spBase] <= '{pc: seqCmd.returnPc, flags: seqCmd.flags};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp_reg <= '0;
		end else begin
			sp_reg <= SP_W'(spBase + SP_W'(pushDo));
		end
	end

	// Sequencer answers, each one clock after its cause.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			take_reg         <= 1'b0;
			vector_reg       <= '0;
			resume_reg       <= 1'b0;
			restoreValid_reg <= 1'b0;
			restore_reg      <= '0;
		end else begin
			take_reg         <= take;
			resume_reg       <= haltResume;
			restoreValid_reg <= popDo;
			if (take) begin
				vector_reg <= takeVector;
			end
			if (popDo) begin
				restore_reg <= stack_reg[spBase];
			end
		end
	end

	assign seqRsp.take         = take_reg;
	assign seqRsp.vector       = vector_reg;
	assign seqRsp.resume       = resume_reg;
	assign seqRsp.restoreValid = restoreValid_reg;
	assign seqRsp.restorePc    = restore_reg.pc;
	assign seqRsp.restoreFlags = restore_reg.flags;
	assign seqRsp.halted       = halted;
	assign seqRsp.stopped      = (state_reg == irq_halt_pkg::ST_STOP);

	// Read data is captured in the setup phase so that prdata comes from a flip-flop.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end else if (apbSetup) begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
			if (apbReq.paddr == irq_halt_pkg::CTRL_OFFSET) begin
				prdata_reg <= irq_halt_pkg::DATA_W'(ctrl_reg);
			end else if (apbReq.paddr == irq_halt_pkg::REQ_OFFSET) begin
				prdata_reg <= irq_halt_pkg::DATA_W'(req_reg);
			end else if (apbReq.paddr == irq_halt_pkg::STATUS_OFFSET) begin
				prdata_reg[irq_halt_pkg::ST_PIN_BIT]  <= extIntPin;
				prdata_reg[irq_halt_pkg::ST_HALT_BIT] <= halted;
				prdata_reg[irq_halt_pkg::ST_STOP_BIT] <= (state_reg == irq_halt_pkg::ST_STOP);
				prdata_reg[irq_halt_pkg::ST_DEPTH_LSB +: SP_W] <= sp_reg;
			end else begin
				slverr_reg <= 1'b1;
			end
		end
	end

	assign apbRsp.prdata  = prdata_reg;
	assign apbRsp.pready  = apbReq.psel & apbReq.penable;
	assign apbRsp.pslverr = apbReq.psel & apbReq.penable & slverr_reg;

	property p_extEdge;
		@(posedge clk_sys) disable iff (rst)
		(pinPrimed_reg && !ctrl_reg[irq_halt_pkg::CTRL_EDGE_BIT] && !extPinPrev_reg && extIntPin)
		|=> req_reg[irq_halt_pkg::SRC_EXT];
	endproperty
	a_extEdge: assert property (p_extEdge) else $error("rising edge not latched");

	property p_maskedHeld;
		@(posedge clk_sys) disable iff (rst)
		(req_reg[irq_halt_pkg::SRC_INTERVAL] && !enableVec[irq_halt_pkg::SRC_INTERVAL] && !writeReq)
		|=> req_reg[irq_halt_pkg::SRC_INTERVAL] &&
		    !(take_reg && vector_reg == irq_halt_pkg::VEC_INTERVAL);
	endproperty
	a_maskedHeld: assert property (p_maskedHeld) else $error("masked request lost");

	property p_acceptClears;
		@(posedge clk_sys) disable iff (rst)
		(take && enabledPend[irq_halt_pkg::SRC_TIMER8] && !timer8Event && !writeReq)
		|=> !req_reg[irq_halt_pkg::SRC_TIMER8] && take_reg &&
		    vector_reg == irq_halt_pkg::VEC_TIMER8 ##1 !take_reg || halted;
	endproperty
	a_acceptClears: assert property (p_acceptClears) else $error("accept did not clear");

	property p_priority;
		@(posedge clk_sys) disable iff (rst)
		(take && !enabledPend[irq_halt_pkg::SRC_TIMER8] && enabledPend[irq_halt_pkg::SRC_EXT])
		|=> vector_reg == irq_halt_pkg::VEC_EXT && req_reg[irq_halt_pkg::SRC_INTERVAL] ==
		    ($past(writeReq ? apbReq.pwdata[irq_halt_pkg::SRC_INTERVAL] :
		           req_reg[irq_halt_pkg::SRC_INTERVAL]) | $past(intervalTimerEvent));
	endproperty
	a_priority: assert property (p_priority) else $error("wrong priority order");

	property p_twoCycle;
		@(posedge clk_sys) disable iff (rst)
		(inRun && seqCmd.cycleEnd && seqCmd.secondPending) |=> !take_reg;
	endproperty
	a_twoCycle: assert property (p_twoCycle) else $error("accept inside two-cycle op");

	property p_enableDelay;
		@(posedge clk_sys) disable iff (rst)
		(inRun && seqCmd.cycleEnd && seqCmd.masterEnableInstr && !masterEnable_reg &&
		 !masterArm_reg) |=> !take_reg && !masterEnable_reg;
	endproperty
	a_enableDelay: assert property (p_enableDelay) else $error("enable took effect early");

	property p_acceptDisables;
		@(posedge clk_sys) disable iff (rst)
		take |=> !masterEnable_reg && take_reg && sp_reg == $past(pushDo ? spBase + 1'b1 : spBase);
	endproperty
	a_acceptDisables: assert property (p_acceptDisables) else $error("accept left enable");

	property p_haltNop;
		@(posedge clk_sys) disable iff (rst)
		(inRun && seqCmd.cycleEnd && seqCmd.haltInstr && !seqCmd.secondPending &&
		 seqCmd.operand == irq_halt_pkg::HALT_OP_TIMER && req_reg[irq_halt_pkg::SRC_TIMER8])
		|=> state_reg == irq_halt_pkg::ST_RUN;
	endproperty
	a_haltNop: assert property (p_haltNop) else $error("halt entered with timer flag");

	property p_portResume;
		@(posedge clk_sys) disable iff (rst)
		(state_reg == irq_halt_pkg::ST_HALT_ANY && portLow && enabledPend == '0)
		|=> inRun && resume_reg && !take_reg ##1 !resume_reg;
	endproperty
	a_portResume: assert property (p_portResume) else $error("port release failed");

	property p_timerRelease;
		@(posedge clk_sys) disable iff (rst)
		(state_reg == irq_halt_pkg::ST_HALT_TIMER && req_reg[irq_halt_pkg::SRC_TIMER8])
		|=> inRun && (take_reg != resume_reg) &&
		    take_reg == $past(masterEnable_reg && enableVec[irq_halt_pkg::SRC_TIMER8]);
	endproperty
	a_timerRelease: assert property (p_timerRelease) else $error("timer halt exit wrong");

	property p_restore;
		@(posedge clk_sys) disable iff (rst)
		popDo |=> restoreValid_reg ##1 !restoreValid_reg || $past(popDo);
	endproperty
	a_restore: assert property (p_restore) else $error("return restore late");

	property p_stopHold;
		@(posedge clk_sys) disable iff (rst)
		(state_reg == irq_halt_pkg::ST_STOP && portsAllHigh) |=> state_reg == irq_halt_pkg::ST_STOP;
	endproperty
	a_stopHold: assert property (p_stopHold) else $error("stop left without port low");

	property p_coverTake;
		@(posedge clk_sys) disable iff (rst) normalTake ##1 take_reg;
	endproperty
	c_coverTake: cover property (p_coverTake);

	property p_coverHaltBranch;
		@(posedge clk_sys) disable iff (rst) haltTake;
	endproperty
	c_coverHaltBranch: cover property (p_coverHaltBranch);

	property p_coverStopExit;
		@(posedge clk_sys) disable iff (rst) stopRelease ##1 halted;
	endproperty
	c_coverStopExit: cover property (p_coverStopExit);

endmodule

// ### hdl/irq_halt_pkg.sv
package irq_halt_pkg;

	localparam int PC_W        = 12;
	localparam int FLAG_W      = 5;
	localparam int STACK_DEPTH = 3;
	localparam int SRC_N       = 3;
	localparam int PORT_W      = 4;
	localparam int OP_W        = 4;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	localparam int CTRL_W      = 4;

	// Source index doubles as priority: lower index wins.
	localparam int SRC_TIMER8   = 0;
	localparam int SRC_EXT      = 1;
	localparam int SRC_INTERVAL = 2;

	localparam logic [PC_W-1:0] VEC_TIMER8   = 12'h003;
	localparam logic [PC_W-1:0] VEC_EXT      = 12'h002;
	localparam logic [PC_W-1:0] VEC_INTERVAL = 12'h001;

	localparam logic [OP_W-1:0] HALT_OP_TIMER = 4'h2;
	localparam logic [OP_W-1:0] HALT_OP_ANY   = 4'h8;
	localparam logic [OP_W-1:0] STOP_OP_PORT  = 4'h8;

	localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] REQ_OFFSET    = 32'h0000_0004;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 32'h0000_0008;

	localparam int CTRL_EDGE_BIT   = 0;
	localparam int CTRL_T8_EN_BIT  = 1;
	localparam int CTRL_EXT_EN_BIT = 2;
	localparam int CTRL_INT_EN_BIT = 3;

	localparam int ST_PIN_BIT   = 0;
	localparam int ST_HALT_BIT  = 1;
	localparam int ST_STOP_BIT  = 2;
	localparam int ST_DEPTH_LSB = 4;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [SRC_N-1:0]  REQ_RESET  = 3'h0;

	typedef enum logic [1:0] {
		ST_RUN        = 2'b00,
		ST_HALT_TIMER = 2'b01,
		ST_HALT_ANY   = 2'b10,
		ST_STOP       = 2'b11
	} standby_state_t;

	typedef struct packed {
		logic              cycleEnd;
		logic              secondPending;
		logic              masterEnableInstr;
		logic              masterDisableInstr;
		logic              returnInstr;
		logic              haltInstr;
		logic              stopInstr;
		logic [OP_W-1:0]   operand;
		logic [PC_W-1:0]   returnPc;
		logic [FLAG_W-1:0] flags;
	} seq_cmd_t;

	typedef struct packed {
		logic              take;
		logic [PC_W-1:0]   vector;
		logic              resume;
		logic              restoreValid;
		logic [PC_W-1:0]   restorePc;
		logic [FLAG_W-1:0] restoreFlags;
		logic              halted;
		logic              stopped;
	} seq_rsp_t;

	typedef struct packed {
		logic [PC_W-1:0]   pc;
		logic [FLAG_W-1:0] flags;
	} stack_entry_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_rsp_t;

endpackage

// ### test/seq_model.sv
module seq_model (
	// Clock.
	input  wire logic                   clk_sys,
	// Sequencer command.
	output      irq_halt_pkg::seq_cmd_t seqCmd
);
	timeunit 1ns;
	timeprecision 100ps;

	initial seqCmd = '0;

	// Kinds: 0 plain, 1 enable, 2 disable, 3 return, 4 halt, 5 stop.
	// Software puts the enable right before a return and never clears an enabled request
	// just before a halt, so one-cycle instruction shapes are all that is needed.
	task automatic issue(input int kind, input logic sec, input logic [3:0] op);
		@(posedge clk_sys);
		seqCmd.cycleEnd           <= 1'b1;
		seqCmd.secondPending      <= sec;
		seqCmd.masterEnableInstr  <= kind == 1;
		seqCmd.masterDisableInstr <= kind == 2;
		seqCmd.returnInstr        <= kind == 3;
		seqCmd.haltInstr          <= kind == 4;
		seqCmd.stopInstr          <= kind == 5;
		seqCmd.operand            <= op;
		seqCmd.flags              <= 5'h15;
		seqCmd.returnPc           <= seqCmd.returnPc + 12'h001;
		@(posedge clk_sys);
		seqCmd.cycleEnd <= 1'b0;
		#1;
	endtask
endmodule

// ### test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [31:0] CTL = irq_halt_pkg::CTRL_OFFSET;
	localparam logic [31:0] REQ = irq_halt_pkg::REQ_OFFSET;
	localparam logic [31:0] STS = irq_halt_pkg::STATUS_OFFSET;

	logic                   clk_sys = 1'b0;
	logic                   rst = 1'b1;
	irq_halt_pkg::apb_req_t apbReq = '0;
	irq_halt_pkg::apb_rsp_t apbRsp;
	irq_halt_pkg::seq_cmd_t seqCmd;
	irq_halt_pkg::seq_rsp_t seqRsp;
	logic                   timer8Event = 1'b0;
	logic                   intervalTimerEvent = 1'b0;
	logic                   extIntPin = 1'b0;
	logic [3:0]             wakePortAPins = 4'hf;
	logic [3:0]             wakePortBPins = 4'hf;
	int                     failures = 0;
	int                     checks_done = 0;
	logic [31:0]            rd;
	logic                   err;
	logic                   tk;
	logic                   rs;
	logic [11:0]            pcSaved;

	always #12.5 clk_sys = ~clk_sys;

	interrupt_and_halt_control dut (.clk_sys(clk_sys), .rst(rst), .apbReq(apbReq),
		.apbRsp(apbRsp), .timer8Event(timer8Event), .intervalTimerEvent(intervalTimerEvent),
		.extIntPin(extIntPin), .wakePortAPins(wakePortAPins), .wakePortBPins(wakePortBPins),
		.seqCmd(seqCmd), .seqRsp(seqRsp));
	seq_model cpu (.clk_sys(clk_sys), .seqCmd(seqCmd));

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
		int n;
		@(posedge clk_sys);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
		@(posedge clk_sys);
		apbReq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 16);
		if (apbRsp.pready !== 1'b1) begin
			failures++;
			end_of_test();
		end
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	// Which: 0 interval event, 1 timer event, 2 port pin low; collects pulses for six cycles.
	task automatic wake(input int which);
		@(posedge clk_sys);
		timer8Event <= which == 1;
		intervalTimerEvent <= which == 0;
		wakePortBPins <= (which == 2) ? 4'h7 : 4'hf;
		@(posedge clk_sys);
		timer8Event <= 1'b0;
		intervalTimerEvent <= 1'b0;
		wakePortBPins <= 4'hf;
		tk = 1'b0;
		rs = 1'b0;
		repeat (6) begin
			#1;
			tk |= seqRsp.take;
			rs |= seqRsp.resume;
			@(posedge clk_sys);
		end
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk({seqRsp.take, seqRsp.resume, seqRsp.halted, seqRsp.stopped}, 0);
		apb(0, CTL, 0);
		chk(rd, 0);
		apb(0, 32'h0000_0040, 0);
		chk(err, 1);
		apb(1, REQ, 7);
		cpu.issue(1, 0, 0);
		cpu.issue(0, 0, 0);
		chk(seqRsp.take, 0);
		apb(1, CTL, 32'he);
		cpu.issue(0, 1, 0);
		chk(seqRsp.take, 0);
		cpu.issue(0, 0, 0);
		chk({seqRsp.take, seqRsp.vector}, {1'b1, irq_halt_pkg::VEC_TIMER8});
		pcSaved = seqCmd.returnPc;
		apb(0, REQ, 0);
		chk(rd, 6);
		cpu.issue(0, 0, 0);
		chk(seqRsp.take, 0);
		cpu.issue(1, 0, 0);
		chk(seqRsp.take, 0);
		cpu.issue(3, 0, 0);
		chk({seqRsp.take, seqRsp.restoreValid, seqRsp.restoreFlags}, 7'h75);
		chk(seqRsp.vector, irq_halt_pkg::VEC_EXT);
		chk(seqRsp.restorePc, pcSaved);
		cpu.issue(1, 0, 0);
		cpu.issue(3, 0, 0);
		chk({seqRsp.take, seqRsp.vector}, {1'b1, irq_halt_pkg::VEC_INTERVAL});
		apb(1, REQ, 1);
		cpu.issue(1, 0, 0);
		cpu.issue(2, 0, 0);
		cpu.issue(0, 0, 0);
		chk(seqRsp.take, 0);
		for (int s = 0; s < 2; s++) begin
			apb(1, CTL, s);
			extIntPin <= s[0];
			apb(1, REQ, 0);
			extIntPin <= ~s[0];
			repeat (3) @(posedge clk_sys);
			apb(0, REQ, 0);
			chk(rd, 2);
			apb(1, REQ, 0);
			extIntPin <= s[0];
			repeat (3) @(posedge clk_sys);
			apb(0, REQ, 0);
			chk(rd, 0);
		end
		apb(1, CTL, 2);
		apb(1, REQ, 1);
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_TIMER);
		chk(seqRsp.halted, 0);
		apb(1, REQ, 0);
		cpu.issue(4, 0, 4'h5);
		chk(seqRsp.halted, 0);
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_TIMER);
		chk(seqRsp.halted, 1);
		apb(0, STS, 0);
		chk(rd, 32'h0000_0013);
		wake(1);
		chk({tk, rs, seqRsp.halted}, 3'b010);
		apb(1, REQ, 0);
		cpu.issue(1, 0, 0);
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_TIMER);
		wake(1);
		chk({tk, rs, seqRsp.vector}, {2'b10, irq_halt_pkg::VEC_TIMER8});
		apb(1, CTL, 6);
		wakePortAPins <= 4'he;
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_ANY);
		chk(seqRsp.halted, 0);
		wakePortAPins <= 4'hf;
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_ANY);
		wake(0);
		chk({tk, rs, seqRsp.halted}, 3'b001);
		wake(2);
		chk({tk, rs, seqRsp.halted}, 3'b010);
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_ANY);
		wake(1);
		chk({tk, rs}, 2'b01);
		apb(1, REQ, 0);
		cpu.issue(1, 0, 0);
		cpu.issue(4, 0, irq_halt_pkg::HALT_OP_ANY);
		wake(1);
		chk({tk, rs, seqRsp.vector}, {2'b10, irq_halt_pkg::VEC_TIMER8});
		cpu.issue(5, 0, irq_halt_pkg::STOP_OP_PORT);
		chk(seqRsp.stopped, 1);
		wake(2);
		chk({seqRsp.stopped, seqRsp.halted}, 2'b01);
		end_of_test();
	end
endmodule
